// ---- ssu_pkg.sv ----
// shared constants and types for the two-channel synchronous serial unit
package ssu_pkg;

	// ==========================================================
	// register indexes (byte address = 4 * index)
	localparam logic [15:0] IDX_BUF_LO0 = 16'hf280;
	localparam logic [15:0] IDX_BUF_HI0 = 16'hf281;
	localparam logic [15:0] IDX_CTRL0 = 16'hf282;
	localparam logic [15:0] IDX_FMT0 = 16'hf284;
	localparam logic [15:0] IDX_CLK0 = 16'hf285;
	localparam logic [15:0] IDX_BUF_LO1 = 16'hf288;
	localparam logic [15:0] IDX_BUF_HI1 = 16'hf289;
	localparam logic [15:0] IDX_CTRL1 = 16'hf28a;
	localparam logic [15:0] IDX_FMT1 = 16'hf28c;
	localparam logic [15:0] IDX_CLK1 = 16'hf28d;
	localparam logic [15:0] IDX_BLOCK_CTRL2 = 16'hf290;

	// ==========================================================
	// field positions, masks and reset values
	localparam int CTRL_START = 0;
	localparam int FMT_BIT_ORDER = 0;
	localparam int FMT_OP_LO = 1;
	localparam int FMT_OP_HI = 2;
	localparam int FMT_WORD_LEN = 3;
	localparam int CLK_PHASE = 4;
	localparam int BLK_DIS0 = 0;
	localparam int BLK_DIS1 = 1;
	localparam logic [7:0] FMT_MASK = 8'h0f;
	localparam logic [7:0] CLK_MASK = 8'h1f;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] BLK_RESET = 2'h0;
	localparam logic [15:0] BUF_RESET = 16'h0000;

	// ==========================================================
	// clock-select codes
	localparam logic [3:0] CK_LS_DIV1 = 4'h0;
	localparam logic [3:0] CK_LS_DIV2 = 4'h1;
	localparam logic [3:0] CK_HS_DIV4 = 4'h2;
	localparam logic [3:0] CK_HS_DIV8 = 4'h3;
	localparam logic [3:0] CK_HS_DIV16 = 4'h4;
	localparam logic [3:0] CK_HS_DIV32 = 4'h5;
	localparam logic [3:0] CK_EXT_MAIN = 4'h6;
	localparam logic [3:0] CK_EXT_ALT = 4'h7;
	localparam logic [3:0] CK_HS_DIV1 = 4'h8;
	localparam logic [3:0] CK_HS_DIV2 = 4'h9;

	// ==========================================================
	// timing: pclk, high-speed and low-speed source periods
	localparam int CLK_PERIOD_NS = 4;
	localparam int HS_PERIOD_NS = 240;
	localparam int LS_PERIOD_NS = 30518;
	localparam int HS_CYCLES = HS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int LS_CYCLES = LS_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [3:0] LAST_BIT8 = 4'h7;
	localparam logic [3:0] LAST_BIT16 = 4'hf;

	// ==========================================================
	// channel shift state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT_LEAD = 3'b010,
		ST_WAIT_TRAIL = 3'b100
	} ssu_state_t;

endpackage : ssu_pkg

// ---- ssu_reg_if.sv ----
// register access link between the bus front end and one channel
`timescale 1ns/1ps
interface ssu_reg_if;
	logic block_off;
	logic wr_buf_lo;
	logic wr_buf_hi;
	logic wr_ctrl;
	logic wr_fmt;
	logic wr_clk;
	logic [15:0] wdata;
	logic [15:0] rx;
	logic [7:0] ctrl;
	logic [7:0] fmt;
	logic [7:0] clk;

	modport regs (
		output block_off, wr_buf_lo, wr_buf_hi, wr_ctrl, wr_fmt, wr_clk, wdata,
		input rx, ctrl, fmt, clk
	);
	modport chan (
		input block_off, wr_buf_lo, wr_buf_hi, wr_ctrl, wr_fmt, wr_clk, wdata,
		output rx, ctrl, fmt, clk
	);
endinterface : ssu_reg_if

// ---- ssu_sync2.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssu_sync2 #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// ==========================================================
	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= '1;
			q <= '1;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : ssu_sync2

// ---- ssu_sync_serial_unit.sv ----
// two-channel synchronous serial unit with apb register front end
//
// Operation
// - channel 0 held reset while disabled
// - channel 1 held reset while disabled
// - two independent 8/16-bit serial channels
// - buffer write loads tx, read returns rx
// - start bit begins transfer, hardware clears
// - reset clears every start bit
// - format bit 0 selects lsb/msb first
// - format bits 2:1 select operation
// - format bit 3 selects 8/16 bits
// - clock-select code chooses transfer clock rate
// - internal clock master, external clock slave
// - clock bit 4 selects output phase
// - phase 0 idles high, 1 low
// - completion pulses done, clears start
// - receive-only holds serial out high
`timescale 1ns/1ps
module ssu_channel
	import ssu_pkg::*;
#(
	parameter int LS_CYC = ssu_pkg::LS_CYCLES,
	parameter bit HAS_ALT = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	ssu_reg_if.chan rif,
	input wire logic sin_pin,
	input wire logic sck_in,
	input wire logic alt_sck_in,
	output logic sck_out,
	output logic sck_oe_n,
	output logic sout,
	output logic done
);
	typedef struct packed {
		ssu_state_t state;
		logic [7:0] fmt;
		logic [7:0] clk;
		logic start;
		logic [15:0] tx;
		logic [15:0] rx;
		logic [3:0] cnt;
		logic [15:0] timer;
		logic sck;
		logic sout;
		logic sck_prev;
		logic done;
	} ssu_chan_t;

	localparam ssu_chan_t CH_RESET = '{
		state: ST_IDLE, fmt: REG_RESET, clk: REG_RESET, start: 1'b0,
		tx: BUF_RESET, rx: BUF_RESET, cnt: 4'h0, timer: 16'h0000,
		sck: 1'b1, sout: 1'b1, sck_prev: 1'b1, done: 1'b0
	};
	localparam logic [15:0] LS_HALF = 16'(LS_CYC / 2);
	localparam logic [15:0] LS_FULL = 16'(LS_CYC);
	localparam logic [15:0] HS_HALF = 16'(HS_CYCLES / 2);
	localparam logic [15:0] HS_FULL = 16'(HS_CYCLES);

	ssu_chan_t cur;
	ssu_chan_t next_cur;
	logic [2:0] pins_sync;
	logic s_sin;
	logic s_sck;
	logic s_alt;
	logic [3:0] code;
	logic master;
	logic legal;
	logic idle_lvl;
	logic tx_en;
	logic rx_en;
	logic lead;
	logic trail;
	logic ext_sck;
	logic [3:0] last;
	logic [3:0] idx;
	logic [15:0] half;

	// ==========================================================
	// pin synchronisers
	ssu_sync2 #(.W(3)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({alt_sck_in, sck_in, sin_pin}),
		.q(pins_sync)
	);
	assign s_sin = pins_sync[0];
	assign s_sck = pins_sync[1];
	assign s_alt = pins_sync[2];

	// ==========================================================
	// mode decode
	always_comb
	begin
		code = cur.clk[3:0];
		idle_lvl = ~cur.clk[CLK_PHASE];
		tx_en = cur.fmt[FMT_OP_HI];
		rx_en = cur.fmt[FMT_OP_LO];
		last = cur.fmt[FMT_WORD_LEN] ? LAST_BIT16 : LAST_BIT8;
		idx = cur.fmt[FMT_BIT_ORDER] ? last - cur.cnt : cur.cnt;
		master = 1'b1;
		legal = 1'b1;
		half = LS_HALF;
		// transfer clock rate per code, half period in pclk cycles
		case (code)
			CK_LS_DIV1: half = LS_HALF;
			CK_LS_DIV2: half = LS_FULL;
			CK_HS_DIV4: half = 16'(HS_CYCLES * 2);
			CK_HS_DIV8: half = 16'(HS_CYCLES * 4);
			CK_HS_DIV16: half = 16'(HS_CYCLES * 8);
			CK_HS_DIV32: half = 16'(HS_CYCLES * 16);
			CK_HS_DIV1: half = HS_HALF;
			CK_HS_DIV2: half = HS_FULL;
			CK_EXT_MAIN: master = 1'b0;
			CK_EXT_ALT:
			begin
				master = 1'b0;
				legal = HAS_ALT;
			end
			default:
			begin
				master = 1'b0;
				legal = 1'b0;
			end
		endcase
		if (half == 16'h0000)
			half = 16'h0001;
		ext_sck = (HAS_ALT && code == CK_EXT_ALT) ? s_alt : s_sck;
		// edges relative to the idle level
		if (master)
		begin
			lead = cur.state == ST_WAIT_LEAD && cur.timer == 16'h0000;
			trail = cur.state == ST_WAIT_TRAIL && cur.timer == 16'h0000;
		end
		else
		begin
			lead = ext_sck != idle_lvl && cur.sck_prev == idle_lvl;
			trail = ext_sck == idle_lvl && cur.sck_prev != idle_lvl;
		end
	end

	// ==========================================================
	// registers and shift engine
	always_comb
	begin
		next_cur = cur;
		next_cur.done = 1'b0;
		next_cur.sck_prev = ext_sck;
		if (cur.timer != 16'h0000)
			next_cur.timer = cur.timer - 16'h0001;
		// transfer sequencing, one bit per clock period
		case (cur.state)
			ST_IDLE:
			begin
				next_cur.sck = idle_lvl;
				next_cur.sout = 1'b1;
			end
			ST_WAIT_LEAD:
			begin
				if (lead)
				begin
					next_cur.sck = ~idle_lvl;
					next_cur.sout = tx_en ? cur.tx[idx] : 1'b1;
					next_cur.timer = half - 16'h0001;
					next_cur.state = ST_WAIT_TRAIL;
				end
			end
			ST_WAIT_TRAIL:
			begin
				if (trail)
				begin
					next_cur.sck = idle_lvl;
					if (rx_en)
						next_cur.rx[idx] = s_sin;
					next_cur.timer = half - 16'h0001;
					if (cur.cnt == last)
					begin
						next_cur.state = ST_IDLE;
						next_cur.start = 1'b0;
						next_cur.done = 1'b1;
						// last bit holds one cycle past the final sample, idle then drives high
					end
					else
					begin
						next_cur.cnt = cur.cnt + 4'h1;
						next_cur.state = ST_WAIT_LEAD;
					end
				end
			end
			default: next_cur.state = ST_IDLE;
		endcase
		// software writes
		if (rif.wr_buf_lo)
			next_cur.tx[7:0] = rif.wdata[7:0];
		if (rif.wr_buf_hi)
			next_cur.tx[15:8] = rif.wdata[15:8];
		if (rif.wr_fmt)
			next_cur.fmt = rif.wdata[7:0] & FMT_MASK;
		if (rif.wr_clk)
			next_cur.clk = rif.wdata[7:0] & CLK_MASK;
		// start accepted only when idle with a usable mode
		if (rif.wr_ctrl && rif.wdata[CTRL_START] && !cur.start && legal
			&& (tx_en || rx_en))
		begin
			next_cur.start = 1'b1;
			next_cur.cnt = 4'h0;
			next_cur.timer = half - 16'h0001;
			next_cur.state = ST_WAIT_LEAD;
		end
		// block disable holds everything at reset
		if (rif.block_off)
			next_cur = CH_RESET;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur <= CH_RESET;
		else
			cur <= next_cur;
	end

	// ==========================================================
	// outputs
	assign sck_out = cur.sck;
	assign sck_oe_n = ~(master && !rif.block_off);
	assign sout = cur.sout;
	assign done = cur.done;
	assign rif.rx = cur.rx;
	assign rif.ctrl = {7'h00, cur.start};
	assign rif.fmt = cur.fmt;
	assign rif.clk = cur.clk;
endmodule : ssu_channel

module ssu_sync_serial_unit
	import ssu_pkg::*;
#(
	parameter int LS_CYC = ssu_pkg::LS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ch0_serial_in_pin,
	input wire logic ch0_serial_clock_pin_in,
	input wire logic ch0_alt_serial_clock_pin_in,
	output logic ch0_serial_clock_pin_out,
	output logic ch0_serial_clock_pin_oe_n,
	output logic ch0_serial_out_pin,
	output logic ch0_transfer_done,
	input wire logic ch1_serial_in_pin,
	input wire logic ch1_serial_clock_pin_in,
	output logic ch1_serial_clock_pin_out,
	output logic ch1_serial_clock_pin_oe_n,
	output logic ch1_serial_out_pin,
	output logic ch1_transfer_done
);
	typedef struct packed {
		logic [1:0] blk;
		logic [31:0] rdata;
		logic slverr;
	} ssu_bus_t;

	ssu_bus_t cur;
	ssu_bus_t next_cur;
	ssu_reg_if rif0 ();
	ssu_reg_if rif1 ();
	logic [15:0] idx;
	logic [31:0] rd;
	logic miss;
	logic wr;
	logic [4:0] w0;
	logic [4:0] w1;
	logic [15:0] wd;

	// ==========================================================
	// apb decode, read data latched in setup, write in access
	always_comb
	begin
		next_cur = cur;
		idx = paddr[17:2];
		wr = psel && penable && pwrite;
		rd = 32'h00000000;
		miss = 1'b0;
		w0 = 5'h00;
		w1 = 5'h00;
		wd = pwdata[15:0];
		// w bits: buf_lo, buf_hi, ctrl, fmt, clk
		case (idx)
			IDX_BUF_LO0:
			begin
				rd = {16'h0000, rif0.rx};
				w0[0] = pstrb[0];
				w0[1] = pstrb[1];
			end
			IDX_BUF_HI0:
			begin
				rd = {24'h000000, rif0.rx[15:8]};
				w0[1] = pstrb[0];
				wd = {pwdata[7:0], 8'h00};
			end
			IDX_CTRL0: begin rd = {24'h000000, rif0.ctrl}; w0[2] = pstrb[0]; end
			IDX_FMT0: begin rd = {24'h000000, rif0.fmt}; w0[3] = pstrb[0]; end
			IDX_CLK0: begin rd = {24'h000000, rif0.clk}; w0[4] = pstrb[0]; end
			IDX_BUF_LO1:
			begin
				rd = {16'h0000, rif1.rx};
				w1[0] = pstrb[0];
				w1[1] = pstrb[1];
			end
			IDX_BUF_HI1:
			begin
				rd = {24'h000000, rif1.rx[15:8]};
				w1[1] = pstrb[0];
				wd = {pwdata[7:0], 8'h00};
			end
			IDX_CTRL1: begin rd = {24'h000000, rif1.ctrl}; w1[2] = pstrb[0]; end
			IDX_FMT1: begin rd = {24'h000000, rif1.fmt}; w1[3] = pstrb[0]; end
			IDX_CLK1: begin rd = {24'h000000, rif1.clk}; w1[4] = pstrb[0]; end
			IDX_BLOCK_CTRL2:
			begin
				rd = {30'h00000000, cur.blk};
				if (wr && pstrb[0])
					next_cur.blk = pwdata[1:0];
			end
			default: miss = 1'b1;
		endcase
		if (paddr[31:18] != 14'h0000 || paddr[1:0] != 2'h0)
		begin
			miss = 1'b1;
			rd = 32'h00000000;
			w0 = 5'h00;
			w1 = 5'h00;
			next_cur.blk = cur.blk;
		end
		if (!wr)
		begin
			w0 = 5'h00;
			w1 = 5'h00;
		end
		if (psel && !penable)
		begin
			next_cur.rdata = pwrite ? 32'h00000000 : rd;
			next_cur.slverr = miss;
		end
	end

	// bus state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur <= '{blk: BLK_RESET, rdata: 32'h00000000, slverr: 1'b0};
		else
			cur <= next_cur;
	end

	// ==========================================================
	// channel links
	assign rif0.block_off = cur.blk[BLK_DIS0];
	assign rif1.block_off = cur.blk[BLK_DIS1];
	assign {rif0.wr_clk, rif0.wr_fmt, rif0.wr_ctrl, rif0.wr_buf_hi, rif0.wr_buf_lo} = w0;
	assign {rif1.wr_clk, rif1.wr_fmt, rif1.wr_ctrl, rif1.wr_buf_hi, rif1.wr_buf_lo} = w1;
	assign rif0.wdata = wd;
	assign rif1.wdata = wd;
	assign prdata = cur.rdata;
	assign pslverr = cur.slverr;
	assign pready = psel && penable;

	// two independent channels, only channel 0 has an alternate clock pin
	ssu_channel #(.LS_CYC(LS_CYC), .HAS_ALT(1'b1)) u_ch0 (
		.pclk(pclk),
		.presetn(presetn),
		.rif(rif0.chan),
		.sin_pin(ch0_serial_in_pin),
		.sck_in(ch0_serial_clock_pin_in),
		.alt_sck_in(ch0_alt_serial_clock_pin_in),
		.sck_out(ch0_serial_clock_pin_out),
		.sck_oe_n(ch0_serial_clock_pin_oe_n),
		.sout(ch0_serial_out_pin),
		.done(ch0_transfer_done)
	);
	ssu_channel #(.LS_CYC(LS_CYC), .HAS_ALT(1'b0)) u_ch1 (
		.pclk(pclk),
		.presetn(presetn),
		.rif(rif1.chan),
		.sin_pin(ch1_serial_in_pin),
		.sck_in(ch1_serial_clock_pin_in),
		.alt_sck_in(1'b1),
		.sck_out(ch1_serial_clock_pin_out),
		.sck_oe_n(ch1_serial_clock_pin_oe_n),
		.sout(ch1_serial_out_pin),
		.done(ch1_transfer_done)
	);
endmodule : ssu_sync_serial_unit

// ---- ssu_chk.sv ----
// assertion checker for the two-channel synchronous serial unit
`timescale 1ns/1ps
module ssu_chk #(
	parameter int LS_CYC = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic ch0_serial_clock_pin_out,
	input wire logic ch0_serial_clock_pin_oe_n,
	input wire logic ch0_serial_out_pin,
	input wire logic ch0_transfer_done,
	input wire logic ch1_serial_clock_pin_oe_n,
	input wire logic ch1_transfer_done
);
	import ssu_pkg::*;
	// ==========================================
	// mirror of the setup that steers the pins
	logic [7:0] clk0, clk1, fmt0;
	logic [1:0] blk;
	logic wr;
	assign wr = psel && penable && pwrite && pstrb[0];
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blk <= 2'h0;
			clk0 <= 8'h00;
			clk1 <= 8'h00;
			fmt0 <= 8'h00;
		end
		else
		begin
			if (wr && paddr == {14'h0, IDX_BLOCK_CTRL2, 2'b00})
				blk <= pwdata[1:0];
			if (wr && paddr == {14'h0, IDX_CLK0, 2'b00})
				clk0 <= pwdata[7:0];
			if (wr && paddr == {14'h0, IDX_FMT0, 2'b00})
				fmt0 <= pwdata[7:0];
			if (wr && paddr == {14'h0, IDX_CLK1, 2'b00})
				clk1 <= pwdata[7:0];
			// a disabled channel drops back to reset values
			if (blk[0])
			begin
				clk0 <= 8'h00;
				fmt0 <= 8'h00;
			end
			if (blk[1])
				clk1 <= 8'h00;
		end
	end
	function automatic logic int_ck(input logic [7:0] c);
		return c[3:0] < 4'h6 || c[3:0] == 4'h8 || c[3:0] == 4'h9;
	endfunction : int_ck
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// clock pin direction, phase, pacing and data pins
	master_pin0_a: assert property (ch0_serial_clock_pin_oe_n == !(int_ck(clk0) && !blk[0]))
		else $error("ch0 clock pin enable wrong");
	master_pin1_a: assert property (ch1_serial_clock_pin_oe_n == !(int_ck(clk1) && !blk[1]))
		else $error("ch1 clock pin enable wrong");
	done_pulse0_a: assert property (ch0_transfer_done |=> !ch0_transfer_done)
		else $error("ch0 done longer than one cycle");
	done_pulse1_a: assert property (ch1_transfer_done |=> !ch1_transfer_done)
		else $error("ch1 done longer than one cycle");
	clock_idle_a: assert property (ch0_transfer_done && !ch0_serial_clock_pin_oe_n
		|=> ch0_serial_clock_pin_out == !clk0[4])
		else $error("ch0 clock not at idle level");
	clock_pace_a: assert property (!ch0_serial_clock_pin_oe_n && $changed(ch0_serial_clock_pin_out)
		|=> $stable(ch0_serial_clock_pin_out)[*3])
		else $error("ch0 clock half period too short");
	rx_only_a: assert property (fmt0[2:1] == 2'b01 |-> ch0_serial_out_pin)
		else $error("ch0 data out not high in receive mode");
	block_off_a: assert property (blk[0] |-> ##1 (ch0_serial_out_pin && !ch0_transfer_done))
		else $error("ch0 active while disabled");
endmodule : ssu_chk
bind ssu_sync_serial_unit ssu_chk #(.LS_CYC(LS_CYC)) u_chk (.*);

// ---- ssu_peer.sv ----
// behavioural serial peripheral facing one channel
`timescale 1ns/1ps
module ssu_peer (
	input wire logic sck,
	input wire logic idle_lvl,
	input wire logic sout,
	input wire logic [15:0] tx,
	output logic sin,
	output logic ext_clk,
	output logic [15:0] cap
);
	// ==========================================
	// shifter: send on leading edge, capture on trailing
	int cnt;
	initial
	begin
		sin = 1'b1;
		ext_clk = 1'b1;
		cap = 16'h0000;
		cnt = 0;
	end
	always @(sck)
	begin
		if (sck !== idle_lvl)
			sin = tx[cnt[3:0]];
		else
		begin
			cap[cnt[3:0]] = sout;
			cnt = cnt + 1;
			sin <= #14 ~sin; // hold ends: show the inverse, not a stale bit
		end
	end
	// link clock of 64 ns, still between frames
	task automatic burst(input int n);
		repeat (2 * n)
		begin
			#32;
			ext_clk = ~ext_clk;
		end
	endtask : burst
	task automatic clear();
		cnt = 0;
	endtask : clear
endmodule : ssu_peer

// ---- test_ssu_sync_serial_unit.sv ----
// self-checking bench for the two-channel synchronous serial unit
`timescale 1ns/1ps
module test_ssu_sync_serial_unit;
	import ssu_pkg::*;
	// ==========================================
	// wiring
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [1:0] sin, sout, sck_o, oe_n, done, ext, idle, sck;
	logic [15:0] mtx [2];
	logic [15:0] cap [2];
	logic [15:0] regs [5] = '{IDX_BUF_LO0, IDX_BUF_HI0, IDX_CTRL0, IDX_FMT0, IDX_CLK0};
	int err_count, checks;
	assign sck = {oe_n[1] ? ext[1] : sck_o[1], oe_n[0] ? ext[0] : sck_o[0]};
	ssu_sync_serial_unit #(.LS_CYC(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch0_serial_in_pin(sin[0]), .ch0_serial_clock_pin_in(sck[0]),
		.ch0_alt_serial_clock_pin_in(sck[0]), .ch0_serial_clock_pin_out(sck_o[0]),
		.ch0_serial_clock_pin_oe_n(oe_n[0]), .ch0_serial_out_pin(sout[0]),
		.ch0_transfer_done(done[0]), .ch1_serial_in_pin(sin[1]),
		.ch1_serial_clock_pin_in(sck[1]), .ch1_serial_clock_pin_out(sck_o[1]),
		.ch1_serial_clock_pin_oe_n(oe_n[1]), .ch1_serial_out_pin(sout[1]),
		.ch1_transfer_done(done[1]));
	for (genvar g = 0; g < 2; g++)
	begin : g_peer
		ssu_peer u_peer (.sck(sck[g]), .idle_lvl(idle[g]), .sout(sout[g]), .tx(mtx[g]),
			.sin(sin[g]), .ext_clk(ext[g]), .cap(cap[g]));
	end
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ==========================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// wait states are the slave's call; only the watchdog ends a hang
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] ba(input logic [15:0] idx, input int ch);
		return {14'h0, idx + 16'(8 * ch), 2'b00};
	endfunction : ba
	// expected word after shifting n bits in the chosen order
	function automatic logic [15:0] ord(input logic [15:0] v, input logic big, input logic wide);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < (wide ? 16 : 8); i++)
			r[i] = big ? v[(wide ? 15 : 7) - i] : v[i];
		return r;
	endfunction : ord
	task automatic xfer(input int ch, input int k);
		logic [3:0] fmt;
		logic [4:0] ck;
		logic [15:0] v;
		int n;
		fmt = {1'($urandom), k == 0 ? 2'b01 : k == 1 ? 2'b10 : k == 5 ? 2'b00 : 2'b11, 1'($urandom)};
		// legal codes only, internal rates 0, 1, 8, 9; slave on main or alternate pin
		ck = (k == 4) ? {4'h3, ch == 0 ? 1'($urandom) : 1'b0}
			: {1'($urandom), 1'($urandom), 2'h0, 1'($urandom)};
		v = 16'($urandom);
		mtx[ch] = 16'($urandom);
		idle[ch] = ~ck[4];
		apb(1'b1, ba(IDX_FMT0, ch), {28'h0, fmt}, 4'h1);
		apb(1'b1, ba(IDX_CLK0, ch), {27'h0, ck}, 4'h1);
		apb(1'b1, ba(IDX_BUF_LO0, ch), {16'h0, v}, 4'h3);
		if (ch == 0)
			g_peer[0].u_peer.clear();
		else
			g_peer[1].u_peer.clear();
		apb(1'b1, ba(IDX_CTRL0, ch), 32'h1, 4'h1);
		apb(1'b0, ba(IDX_CTRL0, ch), 32'h0, 4'h0);
		check(rd, {31'h0, k != 5});
		if (k == 4 && ch == 0)
			g_peer[0].u_peer.burst(fmt[3] ? 16 : 8);
		if (k == 4 && ch == 1)
			g_peer[1].u_peer.burst(fmt[3] ? 16 : 8);
		for (n = 0; n < 1000 && rd[0] === 1'b1; n++)
			apb(1'b0, ba(IDX_CTRL0, ch), 32'h0, 4'h0);
		check(rd, 32'h0);
		apb(1'b0, ba(IDX_BUF_LO0, ch), 32'h0, 4'h0);
		if (fmt[1])
			check(rd & (fmt[3] ? 32'hffff : 32'hff), ord(mtx[ch], fmt[0], fmt[3]));
		if (fmt[2])
			check(cap[ch] & (fmt[3] ? 16'hffff : 16'hff), ord(v, fmt[0], fmt[3]));
		$display("transfer ch=%0d case=%0d ended", ch, k);
	endtask : xfer
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	// ==========================================
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		mtx[0] = 16'h0;
		mtx[1] = 16'h0;
		idle = 2'b11;
		err_count = 0;
		checks = 0;
		void'($urandom(70480));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int ch = 0; ch < 2; ch++)
			foreach (regs[i])
			begin
				apb(1'b0, ba(regs[i], ch), 32'h0, 4'h0);
				check(rd, 32'h0);
			end
		apb(1'b0, 32'h0003_ca01, 32'h0, 4'h0);
		check({31'h0, er}, 32'h1);
		$display("reset values ended");
		for (int ch = 0; ch < 2; ch++)
			for (int k = 0; k < 6; k++)
				xfer(ch, k);
		// system reset in mid-transfer clears the start bit
		apb(1'b1, ba(IDX_FMT0, 0), 32'h6, 4'h1);
		apb(1'b1, ba(IDX_CTRL0, 0), 32'h1, 4'h1);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ba(IDX_CTRL0, 0), 32'h0, 4'h0);
		check(rd, 32'h0);
		$display("mid-run reset ended");
		// abort a running transfer by disabling the channel
		for (int ch = 0; ch < 2; ch++)
		begin
			apb(1'b1, ba(IDX_FMT0, ch), 32'h6, 4'h1);
			apb(1'b1, ba(IDX_CTRL0, ch), 32'h1, 4'h1);
			apb(1'b1, ba(IDX_BLOCK_CTRL2, 0), 32'(1 << ch), 4'h1);
			apb(1'b1, ba(IDX_FMT0, ch), 32'h7, 4'h1);
			apb(1'b0, ba(IDX_FMT0, ch), 32'h0, 4'h0);
			check(rd, 32'h0);
			apb(1'b0, ba(IDX_CTRL0, ch), 32'h0, 4'h0);
			check(rd, 32'h0);
			apb(1'b1, ba(IDX_BLOCK_CTRL2, 0), 32'h0, 4'h1);
			$display("disable ch=%0d ended", ch);
		end
		complete_run();
	end
	initial
	begin
		#200000;
		err_count++;
		complete_run();
	end
endmodule : test_ssu_sync_serial_unit
